// file: design/sirq_regs.svh
// Timing and layout constants for the serialized interrupt link.
`ifndef SIRQ_REGS_SVH
`define SIRQ_REGS_SVH
`define SIRQ_FRAMES        5'd17
`define SIRQ_LINES         16
`define SIRQ_FRAME_CLKS    2'd3
`define SIRQ_PH_SAMPLE     2'd2
`define SIRQ_PH_RECOVER    2'd0
`define SIRQ_PH_TURN       2'd1
`define SIRQ_STOP_QUIET    3'd2
`define SIRQ_STOP_CONT     3'd3
`define SIRQ_START_MIN     3'd4
`define SIRQ_START_MAX     3'd8
`define SIRQ_IDLE_GAP      2'd2
`define SIRQ_MGMT_FRAME    4'd2
`define SIRQ_SER_EN_BIT    6
`define SIRQ_PIN_EN_BIT    7
`endif

// file: design/sirq_pkg.sv
// Types shared by both ends of the serialized interrupt link.
package sirq_pkg;
  // Slave states, one-hot.
  typedef enum logic [3:0] {
    SL_IDLE  = 4'h1,
    SL_START = 4'h2,
    SL_DATA  = 4'h4,
    SL_STOP  = 4'h8
  } sirq_sl_st_t;
  // Host states, one-hot.
  typedef enum logic [4:0] {
    HS_IDLE  = 5'h01,
    HS_START = 5'h02,
    HS_DATA  = 5'h04,
    HS_STOP  = 5'h08,
    HS_GAP   = 5'h10
  } sirq_hs_st_t;
endpackage

// file: design/sirq_if.sv
// Shared serial interrupt wire joining the host and slave ends.
interface sirq_if;
  logic h_out;  // Host drive level.
  logic h_oe;   // Host drives the wire.
  logic s_out;  // Slave drive level.
  logic s_oe;   // Slave drives the wire.
  logic line;   // Resolved level, pulled up when nobody drives.
  assign line = h_oe ? h_out : (s_oe ? s_out : 1'b1);
  modport host  (output h_out, output h_oe, input line);
  modport slave (output s_out, output s_oe, input line);
endinterface

// file: design/sirq_slave.sv
// Device end: reports interrupt levels over the serial interrupt wire.
// Overview of operation
// [R1] Quiet idle: request with one-clock low.
// [R2] Release right after request, never high.
// [R3] No request while a cycle is active.
// [R4] Host holds start low four to eight.
// [R5] Line change requests a cycle.
// [R6] Continuous mode: slave never requests.
// [R7] Host may poll after each stop.
// [R8] Mode changes at stop; reset is continuous.
// [R9] Stop width 2 quiet, 3 continuous.
// [R10] Frames of three clocks from start rise.
// [R11] Sample clock: low only if line low.
// [R12] Recovery high after own low; turn releases.
// [R13] Report regardless of who started.
// [R14] Sample of frame N at 3N-1.
// [R15] Frame map: 1 unused, 2..16 lines.
// [R16] Frame 14 carries interrupt 13.
// [R17] Bit 6 serial, bit 7 pin routing.
// [R18] Software avoids sharing frame three.
// [R19] Quiet restart two clocks after stop.
// [R20] Bus reset tristates; leave continuous.
// [R21] Drive and sample on clock rise.
// [R22] Late change pends a new request.
`include "sirq_regs.svh"
module sirq_slave (
  input  wire logic        ref_clk,          // Bus clock.
  input  wire logic        arst_n,           // Asynchronous reset.
  input  wire logic        host_bus_reset_n, // Bus reset, from pin.
  input  wire logic [15:0] irq_lines,        // Interrupt levels, index = irq.
  input  wire logic        mgmt_irq_n,       // Management interrupt, low.
  input  wire logic [7:0]  mgmt_en2,         // Second mgmt enable register.
  output logic             mgmt_interrupt_out_n, // Dedicated mgmt pin.
  output logic             quiet_mode,       // Current mode is quiet.
  sirq_if.slave            bus
);
  // Whole module state.
  typedef struct packed {
    sirq_pkg::sirq_sl_st_t st;
    logic [2:0]  rst_sync;   // Bus reset synchroniser.
    logic [5:0]  cnt;        // Clocks since start rise, during data frames.
    logic [2:0]  low_w;      // Low width of the start or stop pulse.
    logic        prev_line;  // Wire level last clock.
    logic        quiet;      // Mode for the next cycle.
    logic [16:0] frame_val;  // Level reported per frame this cycle.
    logic [16:0] last_lvl;   // Level last seen per frame.
    logic        pend;       // A change still has to be carried.
    logic        drove_low;  // We drove low in the last sample clock.
    logic        out;
    logic        oe;
    logic        pin_q;
    logic [1:0]  gap;
  } sirq_sl_t;
  sirq_sl_t s_q, s_d;
  logic [16:0] lvl;   // Level per frame, bit 0 unused.
  logic        rst_ok;
  logic [4:0]  fr;
  logic [1:0]  ph;

  // Build per-frame levels; frame index f carries irq f-1, frame three mgmt when routed.
  genvar g;
  generate
    for (g = 2; g < 17; g++) begin : g_map
      if (g == 3) begin : g_mgmt
        // Frame three: management interrupt when routed, else irq 2. [R15]
        assign lvl[g] = mgmt_en2[`SIRQ_SER_EN_BIT] ?
          mgmt_irq_n : irq_lines[g-1]; // [R17]
      end else begin : g_irq
        assign lvl[g] = irq_lines[g-1]; // Frame 14 is irq 13. [R16]
      end
    end
  endgenerate
  assign lvl[1:0] = 2'b11;
  // Bus reset counts as released only while both late synchroniser stages are high.
  assign rst_ok = s_q.rst_sync[2] & s_q.rst_sync[1];

  // Next-state logic.
  always_comb begin
    s_d = s_q;
    fr  = 5'(s_q.cnt / 6'd3) + 5'd1;
    ph  = 2'(s_q.cnt % 6'd3);
    s_d.rst_sync  = {s_q.rst_sync[1:0], host_bus_reset_n};
    s_d.prev_line = bus.line; // [R21]
    s_d.oe  = 1'b0;
    s_d.out = 1'b1;
    s_d.last_lvl = lvl;
    s_d.pin_q = ~(mgmt_en2[`SIRQ_PIN_EN_BIT] & ~mgmt_irq_n); // [R17]
    // Any change on an owned line wants carrying. [R5]
    if (lvl != s_q.last_lvl) begin
      s_d.pend = 1'b1;
    end
    case (s_q.st)
      sirq_pkg::SL_IDLE: begin
        if (s_q.gap != 2'd0) begin
          s_d.gap = s_q.gap - 2'd1; // [R19]
        end
        if (!bus.line) begin
          s_d.st = sirq_pkg::SL_START; // Someone began a start frame.
          s_d.low_w = 3'd1; // This low clock is the first one counted.
        end else if (s_q.quiet && s_q.pend && s_q.gap == 2'd0) begin
          s_d.low_w = 3'd0; // Our own low is counted once it is seen.
          s_d.out = 1'b0; // Pulse is driven next clock below. [R1]
          s_d.oe  = 1'b1; // One clock low, then released. [R2]
          s_d.st  = sirq_pkg::SL_START; // Line now active. [R3] [R6]
        end
      end
      sirq_pkg::SL_START: begin
        // Count the low clocks, so a short stop pulse seen just after a
        // bus reset is never mistaken for a start pulse.
        if (!bus.line && s_q.low_w != 3'd7) begin
          s_d.low_w = s_q.low_w + 3'd1;
        end
        // Count frames from the start pulse rise. [R10]
        if (bus.line && !s_q.prev_line && s_q.low_w < `SIRQ_START_MIN) begin
          s_d.st = sirq_pkg::SL_IDLE;
        end else if (bus.line && !s_q.prev_line) begin
          s_d.st  = sirq_pkg::SL_DATA;
          s_d.cnt = 6'd1;
          s_d.pend = (lvl != s_q.last_lvl);
          s_d.frame_val = lvl; // Reported whoever started. [R13]
        end
      end
      sirq_pkg::SL_DATA: begin
        s_d.cnt = s_q.cnt + 6'd1;
        // Output for next clock, which is clock cnt+1 after the rise.
        if (ph == `SIRQ_PH_SAMPLE - 2'd1 && fr >= 5'd2 && fr <= 5'd16)
        begin
          // Sample clock 3N-1: drive low only for a low level. [R14] [R11]
          s_d.frame_val[fr] = lvl[fr];
          s_d.oe  = ~lvl[fr];
          s_d.out = 1'b0;
          s_d.drove_low = ~lvl[fr];
        end else if (ph == `SIRQ_PH_SAMPLE && s_q.drove_low) begin
          s_d.oe  = 1'b1; // Recovery: drive high after own low. [R12]
          s_d.out = 1'b1;
          s_d.drove_low = 1'b0;
        end
        // Changes of a frame not yet sampled ride this cycle. [R5]
        if (fr < 5'd16 && lvl != s_q.last_lvl) begin
          s_d.pend = 1'b0;
        end
        // A change on a sampled frame stays pending. [R22]
        if (lvl != s_q.last_lvl &&
            ((lvl ^ s_q.last_lvl) & ~((17'h1FFFF << fr) << 1)) != 17'h0)
        begin
          s_d.pend = 1'b1;
        end
        // Stop frame begins with host low after data frames.
        if (!bus.line && s_q.prev_line && fr > `SIRQ_FRAMES - 5'd1) begin
          s_d.st = sirq_pkg::SL_STOP;
          s_d.low_w = 3'd1;
        end
      end
      sirq_pkg::SL_STOP: begin
        if (!bus.line) begin
          s_d.low_w = s_q.low_w + 3'd1;
        end else begin
          // Width decides next mode; changes only here and at bus reset. [R9] [R8]
          s_d.quiet = (s_q.low_w == `SIRQ_STOP_QUIET);
          s_d.gap   = `SIRQ_IDLE_GAP - 2'd1; // [R19]
          s_d.st    = sirq_pkg::SL_IDLE;
        end
      end
      default: s_d.st = sirq_pkg::SL_IDLE;
    endcase
    // Bus reset: released wire, continuous idle. [R20]
    if (!rst_ok) begin
      s_d.st    = sirq_pkg::SL_IDLE;
      s_d.quiet = 1'b0;
      s_d.oe    = 1'b0;
      s_d.pend  = 1'b0;
    end
  end

  // State register on the rising clock edge. [R21]
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: sirq_pkg::SL_IDLE, pin_q: 1'b1, out: 1'b1,
               last_lvl: 17'h1FFFF, frame_val: 17'h1FFFF,
               prev_line: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.s_out = s_q.out;
  assign bus.s_oe  = s_q.oe;
  assign mgmt_interrupt_out_n = s_q.pin_q;
  assign quiet_mode = s_q.quiet;
endmodule

// file: design/sirq_host.sv
// Host end: starts cycles, collects frames, ends with a stop frame.
`include "sirq_regs.svh"
module sirq_host (
  input  wire logic        ref_clk,     // Bus clock.
  input  wire logic        arst_n,      // Asynchronous reset.
  input  wire logic [2:0]  start_extra, // Start hold clocks past first, 3..7.
  input  wire logic        want_quiet,  // Stop with quiet width.
  input  wire logic        poll,        // Start again after each stop.
  output logic [16:0]      frame_lvls,  // Levels per frame, last cycle.
  output logic             cycle_done,  // Pulse: new levels valid.
  sirq_if.host             bus
);
  // Whole module state.
  typedef struct packed {
    sirq_pkg::sirq_hs_st_t st;
    logic [5:0]  cnt;
    logic        first;   // First cycle after reset still owed. [R8]
    logic        prev_line;
    logic [16:0] lv;
    logic        done;
    logic        out;
    logic        oe;
    logic        quiet;
  } sirq_hs_t;
  sirq_hs_t h_q, h_d;
  logic [2:0] hold;
  logic [4:0] fr;

  // Next-state logic.
  always_comb begin
    h_d = h_q;
    h_d.prev_line = bus.line;
    h_d.done = 1'b0;
    h_d.oe   = 1'b0;
    h_d.out  = 1'b1;
    hold = (start_extra < 3'd3) ? 3'd3 : start_extra; // [R4]
    fr   = 5'(h_q.cnt / 6'd3) + 5'd1;
    case (h_q.st)
      sirq_pkg::HS_IDLE: begin
        if (!bus.line && h_q.quiet) begin
          // A slave requested; take over next clock. [R1]
          // Its own low clock counts towards the hold, so the whole
          // pulse stays within four to eight clocks. [R4]
          h_d.st = sirq_pkg::HS_START;
          h_d.cnt = 6'd1;
          h_d.oe = 1'b1;
          h_d.out = 1'b0;
        end else if (h_q.first || poll) begin
          h_d.st = sirq_pkg::HS_START; // [R7]
          h_d.cnt = 6'd0;
          h_d.first = 1'b0;
          h_d.oe = 1'b1;
          h_d.out = 1'b0;
        end
      end
      sirq_pkg::HS_START: begin
        h_d.cnt = h_q.cnt + 6'd1;
        if (6'(hold) > h_q.cnt) begin
          h_d.oe = 1'b1;
          h_d.out = 1'b0;
        end else begin
          h_d.oe = 1'b1; // One high clock, then release. [R4]
          h_d.st = sirq_pkg::HS_DATA;
          h_d.cnt = 6'd0;
        end
      end
      sirq_pkg::HS_DATA: begin
        h_d.cnt = h_q.cnt + 6'd1;
        // Sample clock of frame N is clock 3N-1. [R14]
        if (h_q.cnt % 6'd3 == 6'd2 && fr <= `SIRQ_FRAMES) begin
          h_d.lv[fr - 5'd1] = bus.line;
        end
        // Stop starts after the turn-around clock of the last frame.
        if (h_q.cnt == 6'd3 * 6'(`SIRQ_FRAMES) + 6'd1) begin
          h_d.st = sirq_pkg::HS_STOP;
          h_d.cnt = 6'd0;
          h_d.quiet = want_quiet; // Mode changes only at stop. [R8]
          h_d.oe = 1'b1;
          h_d.out = 1'b0;
        end
      end
      sirq_pkg::HS_STOP: begin
        h_d.cnt = h_q.cnt + 6'd1;
        if (h_q.cnt + 6'd1 < 6'(h_q.quiet ? `SIRQ_STOP_QUIET
                                          : `SIRQ_STOP_CONT)) begin
          h_d.oe = 1'b1;
          h_d.out = 1'b0;
        end else begin
          h_d.oe = 1'b1;
          h_d.st = sirq_pkg::HS_GAP;
          h_d.cnt = 6'd0;
          h_d.done = 1'b1;
        end
      end
      sirq_pkg::HS_GAP: begin
        h_d.st = sirq_pkg::HS_IDLE; // Driven-high clock after stop, then released in idle. [R19]
      end
      default: h_d.st = sirq_pkg::HS_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      h_q <= '{st: sirq_pkg::HS_IDLE, first: 1'b1, prev_line: 1'b1,
               lv: 17'h1FFFF, out: 1'b1, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  assign bus.h_out  = h_q.out;
  assign bus.h_oe   = h_q.oe;
  assign frame_lvls = h_q.lv;
  assign cycle_done = h_q.done;
endmodule

// file: test/sirq_checker.sv
// Concurrent checks on both drivers of the serial interrupt wire.
module sirq_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic h_out,
  input wire logic h_oe,
  input wire logic s_out,
  input wire logic s_oe,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lowc_q; // Consecutive low clocks on the wire.
  logic [2:0] hic_q;  // Consecutive high clocks on the wire.
  logic [5:0] pos_q;  // Clocks since the start rise, zero when idle.
  wire        slow;   // The slave pulls the wire low.
  assign slow = s_oe && !s_out;
  // A low run of four or more can only be a start, so its rise anchors the
  // frame count; stop pulses are too short to be mistaken for one.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowc_q <= 4'h0;
      hic_q <= 3'h0;
      pos_q <= 6'h00;
    end else begin
      lowc_q <= line ? 4'h0 : lowc_q + {3'h0, lowc_q != 4'hF};
      hic_q <= line ? hic_q + {2'h0, hic_q != 3'h7} : 3'h0;
      pos_q <= (line && lowc_q > 4'h3) ? 6'h01 :
               ((pos_q != 6'h00 && pos_q < 6'h34) ? pos_q + 6'h01 : 6'h00);
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  a_low_in_slot:
    assert property (slow && pos_q != 6'h00 |->
      pos_q % 3 == 2 && pos_q > 6'h04 && pos_q < 6'h30)
    else $error("slave low outside a sample slot");
  a_recover_high:
    assert property (slow && pos_q != 6'h00 |=> s_oe && s_out ##1 !s_oe)
    else $error("slave recovery or turn-around wrong");
  a_never_high:
    assert property (s_oe && s_out |-> $past(slow))
    else $error("slave drove high without a low before");
  a_request_pulse:
    assert property (slow && pos_q == 6'h00 |=> !s_oe)
    else $error("slave request longer than one clock");
  a_request_idle:
    assert property (slow && pos_q == 6'h00 |-> hic_q > 3'h1)
    else $error("slave request while the wire is not idle");
  a_start_shape:
    assert property (line && lowc_q > 4'h3 |->
      lowc_q < 4'h9 && h_oe && h_out ##1 !h_oe)
    else $error("start pulse width or release wrong");
  a_turn_release:
    assert property (pos_q % 3 == 1 |-> !s_oe)
    else $error("slave drives in a turn-around clock");
  a_host_silent:
    assert property (pos_q != 6'h00 |-> !h_oe)
    else $error("host drives during data frames");
endmodule

// file: test/serial_irq_slave_tb.sv
// Testbench joining the host and slave ends over the shared wire.
module serial_irq_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        host_bus_reset_n = 1'b1;
  logic [15:0] irq_lines = 16'hFFFF;
  logic        mgmt_irq_n = 1'b1;
  logic [7:0]  mgmt_en2 = 8'h00;
  logic [2:0]  start_extra = 3'h7; // Longest start pulse, eight clocks.
  logic        want_quiet = 1'b0;
  logic        poll = 1'b1;
  logic [16:0] frame_lvls;
  logic        cycle_done;
  logic        mgmt_interrupt_out_n;
  logic        quiet_mode;
  int          bad_count = 0;
  int          tests_run = 0;
  sirq_if sif();
  sirq_host i_sirq_host (.ref_clk(ref_clk), .arst_n(arst_n),
    .start_extra(start_extra), .want_quiet(want_quiet), .poll(poll),
    .frame_lvls(frame_lvls), .cycle_done(cycle_done), .bus(sif));
  sirq_slave i_sirq_slave (.ref_clk(ref_clk), .arst_n(arst_n),
    .host_bus_reset_n(host_bus_reset_n), .irq_lines(irq_lines),
    .mgmt_irq_n(mgmt_irq_n), .mgmt_en2(mgmt_en2),
    .mgmt_interrupt_out_n(mgmt_interrupt_out_n), .quiet_mode(quiet_mode),
    .bus(sif));
  sirq_checker i_sirq_checker (.ref_clk(ref_clk), .arst_n(arst_n),
    .h_out(sif.h_out), .h_oe(sif.h_oe), .s_out(sif.s_out),
    .s_oe(sif.s_oe), .line(sif.line));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // Compare a single flag.
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  // Compare the levels collected for all frames.
  task automatic chk17(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: frames %h not %h", $time, got, exp);
    end
  endtask
  // Levels the host should see: frames 1 and 17 idle high, frame 3 routed.
  function automatic logic [16:0] exp_lv(input logic [15:0] irq,
                                         input logic mg, input logic [7:0] en);
    exp_lv = {1'b1, irq[15:1], 1'b1};
    if (en[6]) exp_lv[2] = mg;
  endfunction
  // Wait a bounded time for the end of a cycle; a timeout is a mismatch.
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cycle_done !== 1'b1 && n < lim);
    chk1(cycle_done, 1'b1);
  endtask
  // Host polls continuously; check mapping and management routing.
  task automatic t_map(input logic [15:0] irq, input logic mg,
                       input logic [7:0] en);
    @(posedge ref_clk);
    irq_lines <= irq;
    mgmt_irq_n <= mg;
    mgmt_en2 <= en;
    wait_done(200);
    wait_done(200);
    chk17(frame_lvls, exp_lv(irq, mg, en));
    chk1(mgmt_interrupt_out_n, en[7] ? mg : 1'b1);
    chk1(quiet_mode, 1'b0);
  endtask
  // Bus reset keeps the slave off the wire even with every line low.
  task automatic t_bus_reset();
    logic seen;
    @(posedge ref_clk);
    host_bus_reset_n <= 1'b0;
    irq_lines <= 16'h0000;
    repeat (6) @(posedge ref_clk);
    seen = 1'b0;
    repeat (150) begin
      @(posedge ref_clk);
      if (sif.s_oe !== 1'b0) seen = 1'b1;
    end
    chk1(seen, 1'b0);
    host_bus_reset_n <= 1'b1;
    repeat (3) wait_done(200);
    chk17(frame_lvls, exp_lv(16'h0000, mgmt_irq_n, mgmt_en2));
  endtask
  // Quiet stop, then a line change makes the slave request a cycle.
  task automatic t_quiet_req();
    @(posedge ref_clk);
    want_quiet <= 1'b1;
    poll <= 1'b0;
    wait_done(200);
    repeat (70) @(posedge ref_clk);
    chk1(quiet_mode, 1'b1);
    irq_lines <= 16'hFFFD;
    wait_done(100);
    chk17(frame_lvls, exp_lv(16'hFFFD, mgmt_irq_n, mgmt_en2));
  endtask
  // A change after its frame was sampled must bring a second cycle.
  task automatic t_late();
    int n;
    @(posedge ref_clk);
    irq_lines <= 16'hFFED;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (sif.line !== 1'b0 && n < 50);
    repeat (16) @(posedge ref_clk);
    irq_lines <= 16'hFFEF;
    wait_done(100);
    chk17(frame_lvls, exp_lv(16'hFFED, mgmt_irq_n, mgmt_en2));
    wait_done(200);
    chk17(frame_lvls, exp_lv(16'hFFEF, mgmt_irq_n, mgmt_en2));
  endtask
  // After a continuous stop the slave stays passive until the host polls.
  task automatic t_cont_passive();
    logic seen;
    @(posedge ref_clk);
    want_quiet <= 1'b0;
    irq_lines <= 16'hFFF7;
    wait_done(100);
    repeat (70) @(posedge ref_clk);
    chk1(quiet_mode, 1'b0);
    irq_lines <= 16'hFFFF;
    seen = 1'b0;
    repeat (150) begin
      @(posedge ref_clk);
      if (cycle_done !== 1'b0 || sif.s_oe !== 1'b0) seen = 1'b1;
    end
    chk1(seen, 1'b0);
    poll <= 1'b1;
    wait_done(200);
    wait_done(200);
    chk17(frame_lvls, exp_lv(16'hFFFF, mgmt_irq_n, mgmt_en2));
  endtask
  // Print the counts and the verdict, then end the run.
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_map(16'hA5C7, 1'b0, 8'h40);
    t_map(16'h5F7E, 1'b0, 8'h80);
    t_bus_reset();
    t_quiet_req();
    t_late();
    t_cont_passive();
    report_and_stop();
  end
  // Watchdog: the sequence needs a few thousand clocks at most.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end
endmodule
